// >>> src/reload_timer.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module reload_timer
    import reload_timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic companion_uf_i,
    output logic pulse_output_pin_o,
    output logic timer_irq_o
);

    timer_state_t q; // Registered state.
    timer_state_t next_q; // Next state.

    logic req; // A bus cycle is being presented.
    logic wr; // Write takes effect at the edge where ack is seen.
    logic [7:0] wdat; // Low byte of write data; all registers are 8 bits wide.
    logic wr_ctrl; // Write to timer_control_reg.
    logic wr_os; // Write to one_shot_control_reg.
    logic wr_out; // Write to output_control_reg.
    logic wr_mode; // Write to timer_mode_reg.
    logic wr_pre; // Write to prescaler_reg.
    logic wr_sec; // Write to secondary_reload_reg.
    logic wr_pri; // Write to primary_reload_reg.
    logic stop_wr; // Forced stop requested in this cycle.
    logic run_both; // Running writes go to reload and counter.
    logic [31:0] rd_data; // Read multiplexer output.
    logic div_tick; // One pulse per count source period.
    logic tick; // Count source gated by count activity.
    logic pre_load; // Direct load of the prescaler counter.
    logic tmr_load; // Direct load of the timer counter.
    logic [7:0] load_val; // Value for a direct load.
    logic [7:0] tmr_next; // Value reloaded on timer underflow.
    logic [7:0] pre_cnt; // Prescaler counter, eight bits wide.
    logic [7:0] tmr_cnt; // Timer counter, eight bits wide.
    logic pre_uf; // Prescaler underflow pulse.
    logic tmr_uf; // Timer underflow pulse.

    // Bus decode. The write is applied on the edge where the master sees ack,
    // so a request held past ack is applied again each time ack returns, every second cycle.
    assign req = cyc_i && stb_i;
    assign wr = req && we_i && q.ack && sel_i[0];
    assign wdat = dat_i[7:0];
    assign wr_ctrl = wr && (adr_i == `OFS_CONTROL);
    assign wr_os = wr && (adr_i == `OFS_ONE_SHOT);
    assign wr_out = wr && (adr_i == `OFS_OUTPUT);
    assign wr_mode = wr && (adr_i == `OFS_MODE);
    assign wr_pre = wr && (adr_i == `OFS_PRESCALER);
    assign wr_sec = wr && (adr_i == `OFS_SECONDARY);
    assign wr_pri = wr && (adr_i == `OFS_PRIMARY);
    assign stop_wr = wr_ctrl && wdat[`BIT_STOP];

    // Read multiplexer. Unmapped offsets read as zero and are still acknowledged.
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (adr_i)
            `OFS_CONTROL:
            begin
                // The forced-stop bit is write-only and reads as zero.
                rd_data[`BIT_START] = q.start;
                rd_data[`BIT_ACTIVE] = q.active;
            end
            `OFS_ONE_SHOT: rd_data[`BIT_OS_FLAG] = q.os_flag;
            `OFS_OUTPUT:
            begin
                rd_data[`BIT_OUT_LEVEL] = q.out_level;
                rd_data[`BIT_OUT_PORT] = q.out_port;
            end
            `OFS_MODE:
            begin
                rd_data[`MODE_HI:`MODE_LO] = q.mode;
                rd_data[`BIT_WRITE_SEL] = q.write_sel;
                rd_data[`SRC_HI:`SRC_LO] = q.src;
            end
            // Prescaler and primary return counter values; secondary returns its reload shadow.
            `OFS_PRESCALER: rd_data[7:0] = pre_cnt;
            `OFS_SECONDARY: rd_data[7:0] = q.sec_shadow;
            `OFS_PRIMARY: rd_data[7:0] = tmr_cnt;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Count source: f1, f2, f8 or the companion timer underflow.
    count_source_divider i_count_source_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(q.src),
        .companion_uf_i(companion_uf_i),
        .tick_o(div_tick)
    );

    // Only a counting timer consumes count source ticks.
    assign tick = div_tick && q.active;

    // Running write-to-both only exists in timer mode with the select bit at 0;
    // elsewhere running writes reach the reload register only.
    assign run_both = q.active && (q.mode == MODE_TIMER) && !q.write_sel;

    // Stopped writes load the counter at once; forced stop loads FFh.
    assign pre_load = stop_wr || (wr_pre && !q.active);
    assign tmr_load = stop_wr || (wr_pri && !q.active);
    assign load_val = stop_wr ? `RESET_RELOAD : wdat;

    // In waveform mode the end of a primary period loads the secondary value,
    // otherwise the primary value is reloaded.
    assign tmr_next = (q.mode == MODE_WAVE && !q.phase) ? q.sec_active : q.pri_reload;

    // Prescaler counts the selected source; its reload is synchronous to it.
    reload_down_counter i_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(tick),
        .load_i(pre_load),
        .load_val_i(load_val),
        .pend_i(wr_pre && run_both),
        .pend_val_i(q.pre_reload),
        .next_val_i(q.pre_reload),
        .cnt_o(pre_cnt),
        .uf_o(pre_uf)
    );

    // Timer counts prescaler underflows, giving a (n+1)(m+1) division.
    reload_down_counter i_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(pre_uf),
        .load_i(tmr_load),
        .load_val_i(load_val),
        .pend_i(wr_pri && run_both),
        .pend_val_i(q.pri_reload),
        .next_val_i(tmr_next),
        .cnt_o(tmr_cnt),
        .uf_o(tmr_uf)
    );

    // Next state: bus answer, register writes, start/stop and output phase.
    always_comb
    begin
        next_q = q;
        next_q.irq = 1'b0;
        // Single-cycle ack; dropped in the cycle after it was given.
        next_q.ack = req && !q.ack;
        if (req && !q.ack)
            next_q.rdata = rd_data;
        // Activity follows the start bit one cycle later.
        next_q.active = q.start;
        // A fresh start always begins with the primary period.
        if (q.start && !q.active)
            next_q.phase = 1'b0;
        if (wr_os && q.mode[`MODE_HI] && q.active && wdat[`BIT_OS_TRIGGER])
            next_q.os_flag = 1'b1;
        if (wr_out)
        begin
            next_q.out_level = wdat[`BIT_OUT_LEVEL];
            next_q.out_port = wdat[`BIT_OUT_PORT];
        end
        if (wr_mode)
        begin
            next_q.mode = mode_t'(wdat[`MODE_HI:`MODE_LO]);
            next_q.write_sel = wdat[`BIT_WRITE_SEL];
            next_q.src = src_t'(wdat[`SRC_HI:`SRC_LO]);
        end
        if (wr_pre)
            next_q.pre_reload = wdat;
        if (wr_sec)
        begin
            // While running, a new secondary value waits for the primary write,
            // so both halves of the waveform change together.
            next_q.sec_shadow = wdat;
            if (!q.active)
                next_q.sec_active = wdat;
        end
        if (wr_pri)
        begin
            next_q.pri_reload = wdat;
            next_q.sec_active = q.sec_shadow;
        end
        if (tmr_uf)
        begin
            if (q.mode == MODE_WAVE)
            begin
                // Interrupt after the secondary period only.
                next_q.phase = !q.phase;
                next_q.irq = q.phase;
            end
            else if (q.mode == MODE_TIMER)
                next_q.irq = 1'b1;
        end
        if (wr_ctrl)
        begin
            next_q.start = wdat[`BIT_START];
            if (wdat[`BIT_STOP])
            begin
                // Forced stop wins over the other updates in this cycle, except an underflow interrupt pulse.
                next_q.start = 1'b0;
                next_q.active = 1'b0;
                next_q.os_flag = 1'b0;
                next_q.pre_reload = `RESET_RELOAD;
                next_q.pri_reload = `RESET_RELOAD;
                next_q.sec_shadow = `RESET_RELOAD;
                next_q.sec_active = `RESET_RELOAD;
                next_q.phase = 1'b0;
            end
        end
        // Pin: waveform level in waveform mode, plain port latch otherwise.
        if (next_q.mode == MODE_WAVE)
            next_q.pin = next_q.phase ^ next_q.out_level;
        else
            next_q.pin = next_q.out_port;
    end

    // State register. Reset leaves everything stopped and cleared, with the reload registers and counters at FFh.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.pre_reload <= `RESET_RELOAD;
            q.pri_reload <= `RESET_RELOAD;
            q.sec_shadow <= `RESET_RELOAD;
            q.sec_active <= `RESET_RELOAD;
        end
        else
            q <= next_q;
    end

    assign ack_o = q.ack;
    assign dat_o = q.rdata;
    assign pulse_output_pin_o = q.pin;
    assign timer_irq_o = q.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_stop_wr;
        stop_wr;
    endsequence

    sequence s_ff_loaded;
        q.pri_reload == `RESET_RELOAD && q.sec_shadow == `RESET_RELOAD
            && q.pre_reload == `RESET_RELOAD && tmr_cnt == `RESET_RELOAD;
    endsequence

    sequence s_start_wr;
        wr_ctrl && wdat[`BIT_START] && !wdat[`BIT_STOP];
    endsequence

    sequence s_started;
        q.start ##1 q.active;
    endsequence

    sequence s_stopped;
        !q.start ##1 !q.active;
    endsequence

    AST_FSTOP_FLAG: assert property (s_stop_wr |=> !q.os_flag && !q.start)
        else $error("Forced stop left a status bit set.");
    AST_OS_GATED: assert property (wr_os && !q.mode[`MODE_HI] |=> q.os_flag == $past(q.os_flag))
        else $error("One-shot register acted outside one-shot modes.");
    AST_FSTOP_FF: assert property (s_stop_wr |=> s_ff_loaded)
        else $error("Forced stop did not load FFh.");
    AST_ALTERNATE: assert property (q.mode == MODE_WAVE && tmr_uf && !q.phase && !stop_wr |=> tmr_cnt == $past(q.sec_active))
        else $error("Secondary value not loaded after primary period.");
    AST_READ_PRI: assert property (req && !q.ack && adr_i == `OFS_PRIMARY |=> dat_o[7:0] == $past(tmr_cnt))
        else $error("Primary read did not return the count.");
    AST_TIMER_RELOAD: assert property (q.mode == MODE_TIMER && tmr_uf && !stop_wr |=> tmr_cnt == $past(q.pri_reload))
        else $error("Timer mode did not reload the primary value.");
    AST_START_SEQ: assert property (s_start_wr |=> s_started)
        else $error("Counting did not begin after start.");
    AST_STOP_SEQ: assert property (wr_ctrl && !wdat[`BIT_START] |=> s_stopped)
        else $error("Counting did not end after stop.");
    AST_IRQ_TIMER: assert property (q.mode == MODE_TIMER && tmr_uf |=> timer_irq_o)
        else $error("Timer underflow raised no interrupt.");
    AST_STOPPED_LOAD: assert property (wr_pri && !q.active |=> tmr_cnt == $past(wdat) && q.pri_reload == $past(wdat))
        else $error("Stopped write did not load the counter.");
    AST_WAVE_PIN: assert property (q.mode == MODE_WAVE && tmr_uf && !wr_out && !wr_mode && !stop_wr |=> pulse_output_pin_o != $past(pulse_output_pin_o))
        else $error("Pin did not invert on underflow.");
    AST_WAVE_IRQ: assert property (q.mode == MODE_WAVE && tmr_uf |=> timer_irq_o == $past(q.phase))
        else $error("Waveform interrupt on wrong period.");

endmodule // reload_timer

// >>> src/reload_timer_consts.svh
`ifndef RELOAD_TIMER_CONSTS_SVH
`define RELOAD_TIMER_CONSTS_SVH
// Overview of operation
// - Forced stop clears one-shot status flag.
// - One-shot register acts only in modes 10b, 11b.
// - Forced stop sets prescaler, primary, secondary FFh.
// - Primary and secondary reload counter alternately.
// - Primary read returns current timer count.
// - Source is f1, f2, f8 or companion.
// - Timer mode reloads primary on underflow.
// - Timer mode divides source by (n+1)(m+1).
// - Writing start bit 1 begins counting.
// - Start 0 or forced stop ends counting.
// - Timer mode interrupt on every underflow.
// - Timer mode ignores secondary, one-shot; pin port.
// - Stopped write loads reload and counter.
// - Running write: control bit 0 both, 1 reload.
// - Timer counts prescaler underflows, prescaler counts source.
// - Counter transfers sync to source, prescaler underflow.
// - Write-to-both reaches counter at next transfer.
// - Waveform mode pin inverts on every underflow.
// - Waveform starts with primary; one-shot unused.
// - Timer and prescaler are eight bits.
// - Forced stop resets start and active bits.
// - Waveform interrupt after secondary underflow, with pin.

// Byte offsets of the registers on the bus.
`define OFS_CONTROL 8'h00
`define OFS_ONE_SHOT 8'h04
`define OFS_OUTPUT 8'h08
`define OFS_MODE 8'h0C
`define OFS_PRESCALER 8'h10
`define OFS_SECONDARY 8'h14
`define OFS_PRIMARY 8'h18

// Field positions.
`define BIT_START 0
`define BIT_ACTIVE 1
`define BIT_STOP 2
`define BIT_OS_TRIGGER 0
`define BIT_OS_FLAG 1
`define BIT_OUT_LEVEL 0
`define BIT_OUT_PORT 1
`define MODE_HI 1
`define MODE_LO 0
`define BIT_WRITE_SEL 3
`define SRC_HI 5
`define SRC_LO 4

// Reset and forced-stop value of the reload registers and counters.
`define RESET_RELOAD 8'hFF

// Divider masks: a tick is issued when all masked divider bits are set.
`define DIV1_MASK 3'h0
`define DIV2_MASK 3'h1
`define DIV8_MASK 3'h7

`endif

// >>> src/reload_timer_pkg.sv
package reload_timer_pkg;

    // Operating modes of the two-bit mode field.
    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_WAVE = 2'b01,
        MODE_ONESHOT = 2'b10,
        MODE_WAIT_ONESHOT = 2'b11
    } mode_t;

    // Count source selection.
    typedef enum logic [1:0] {
        SRC_F1 = 2'b00,
        SRC_F2 = 2'b01,
        SRC_F8 = 2'b10,
        SRC_COMPANION = 2'b11
    } src_t;

    // State of the count source divider.
    typedef struct packed {
        logic [2:0] div;
        logic tick;
    } div_state_t;

    // State of one reload down-counter.
    typedef struct packed {
        logic [7:0] cnt;
        logic pend;
    } cnt_state_t;

    // State of the timer top level.
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic start;
        logic active;
        mode_t mode;
        logic write_sel;
        src_t src;
        logic out_level;
        logic out_port;
        logic os_flag;
        logic [7:0] pre_reload;
        logic [7:0] pri_reload;
        logic [7:0] sec_shadow;
        logic [7:0] sec_active;
        logic phase;
        logic pin;
        logic irq;
    } timer_state_t;

endpackage

// >>> src/count_source_divider.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module count_source_divider
    import reload_timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire src_t src_i,
    input wire logic companion_uf_i,
    output logic tick_o
);

    div_state_t q; // Registered state.
    div_state_t next_q; // Next state.
    logic [2:0] mask; // Divider bits that must all be set for a tick.

    // Next state: free-running divider and one registered tick per source period.
    always_comb
    begin
        next_q = q;
        next_q.div = q.div + 3'h1;
        mask = `DIV1_MASK;
        case (src_i)
            SRC_F2: mask = `DIV2_MASK;
            SRC_F8: mask = `DIV8_MASK;
            default: mask = `DIV1_MASK;
        endcase
        // The companion underflow comes from same-clock logic, so no synchroniser.
        if (src_i == SRC_COMPANION)
            next_q.tick = companion_uf_i;
        else
            next_q.tick = ((q.div & mask) == mask);
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign tick_o = q.tick;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Divide-by-8 ticks land right after the divider wraps.
    AST_F8_SPACING: assert property (src_i == SRC_F8 && $stable(src_i) && tick_o |-> q.div == 3'h0)
        else $error("Divide-by-8 tick out of step.");

endmodule // count_source_divider

// >>> src/reload_down_counter.sv
`timescale 1ns/1ps

module reload_down_counter
    import reload_timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic load_i,
    input wire logic [7:0] load_val_i,
    input wire logic pend_i,
    input wire logic [7:0] pend_val_i,
    input wire logic [7:0] next_val_i,
    output logic [7:0] cnt_o,
    output logic uf_o
);

    cnt_state_t q; // Registered state.
    cnt_state_t next_q; // Next state.

    // A pending write-to-both replaces the next step instead of underflowing.
    assign uf_o = step_i && !q.pend && (q.cnt == 8'h00);
    assign cnt_o = q.cnt;

    // Next state of the counter.
    always_comb
    begin
        next_q = q;
        if (load_i)
        begin
            // Direct load while stopped or on a forced stop.
            next_q.cnt = load_val_i;
            next_q.pend = 1'b0;
        end
        else
        begin
            if (step_i)
            begin
                // Transfers happen only on a step of the feeding source.
                if (q.pend)
                    next_q.cnt = pend_val_i;
                else if (q.cnt == 8'h00)
                    next_q.cnt = next_val_i;
                else
                    next_q.cnt = q.cnt - 8'h01;
                next_q.pend = 1'b0;
            end
            // A new request in the step cycle waits for the following step.
            if (pend_i)
                next_q.pend = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q.cnt <= 8'hFF;
            q.pend <= 1'b0;
        end
        else
            q <= next_q;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DEFER_LOAD: assert property (pend_i && !load_i && !step_i |=> cnt_o == $past(cnt_o))
        else $error("Counter changed on the write itself.");
    AST_UF_RELOAD: assert property (uf_o && !load_i |=> cnt_o == $past(next_val_i))
        else $error("Underflow did not reload the counter.");

endmodule // reload_down_counter

// >>> verif/reload_timer_tb.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"
// Counts one comparison and reports a mismatch at once.
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module reload_timer_tb;
    localparam int LIMIT = 20000; // Cycle ceiling, far above the planned run.
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] val;
    } row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic companion_uf_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic pulse_output_pin_o;
    logic timer_irq_o;
    int mismatches = 0;
    int comparisons = 0;
    int ticks = 0;
    logic comp_on = 1'b0; // Enables the companion underflow pulses.
    logic [1:0] comp_div = 2'h0;
    logic [31:0] rd;
    int gap;
    logic hit;
    int mult [4] = '{1, 2, 8, 3}; // Source period in clocks for f1, f2, f8, companion.
    // Reset table: each address beside the word it must read back.
    row_t rows [8] = '{'{`OFS_CONTROL, 32'h0}, '{`OFS_ONE_SHOT, 32'h0},
        '{`OFS_OUTPUT, 32'h0}, '{`OFS_MODE, 32'h0}, '{`OFS_PRESCALER, 32'hFF},
        '{`OFS_SECONDARY, 32'hFF}, '{`OFS_PRIMARY, 32'hFF}, '{8'h1C, 32'h0}};

    reload_timer i_reload_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .adr_i(adr_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .we_i(we_i),
        .sel_i(sel_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .ack_o(ack_o),
        .companion_uf_i(companion_uf_i),
        .pulse_output_pin_o(pulse_output_pin_o),
        .timer_irq_o(timer_irq_o)
    );

    // The clock toggles every half period of 5 ns.
    always #5 clk_i = ~clk_i;

    // Companion underflow is a one-cycle pulse every third clock, so its period is known.
    always @(posedge clk_i)
    begin
        comp_div <= (comp_div == 2'h2) ? 2'h0 : comp_div + 2'h1;
        companion_uf_i <= comp_on && (comp_div == 2'h2);
    end

    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk_i)
    begin
        ticks <= ticks + 1;
        if (ticks == LIMIT)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled, only the timeout ends a wait.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    // Full-byte write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, 4'hF, q);
    endtask

    // Read into rd.
    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hF, rd);
    endtask

    // Clocks between two consecutive interrupt pulses, i.e. one full period.
    task automatic irq_gap(output int g);
        g = 0;
        do @(posedge clk_i); while (timer_irq_o !== 1'b1);
        do
        begin
            @(posedge clk_i);
            g++;
        end while (timer_irq_o !== 1'b1);
    endtask

    // Clocks until the pin changes, and whether the interrupt came with that change.
    task automatic pin_gap(output int g, output logic irq);
        logic old;
        old = pulse_output_pin_o;
        g = 0;
        do
        begin
            @(posedge clk_i);
            g++;
        end while (pulse_output_pin_o === old);
        irq = timer_irq_o;
    endtask

    // Main sequence: reset, table, then hand-written cases.
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(8'h1C, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            rdr(rows[i].adr);
            `CHK("reset value", rows[i].val, rd)
        end
        // A write without byte lane 0 must leave the register alone.
        wb(1'b1, `OFS_PRIMARY, 32'h05, 4'h0, rd);
        rdr(`OFS_PRIMARY);
        `CHK("masked write", 32'hFF, rd)
        wr(`OFS_PRESCALER, 8'h01);
        wr(`OFS_PRIMARY, 8'h02);
        wr(`OFS_SECONDARY, 8'h03);
        rdr(`OFS_PRIMARY);
        `CHK("stopped primary", 32'h02, rd)
        rdr(`OFS_PRESCALER);
        `CHK("stopped prescaler", 32'h01, rd)
        // Every count source; the period is (1+1)(2+1) source ticks.
        for (int s = 0; s < 4; s++)
        begin
            comp_on = (s == 3);
            wr(`OFS_MODE, {2'h0, s[1:0], 4'h0});
            wr(`OFS_CONTROL, 8'h01);
            rdr(`OFS_CONTROL);
            `CHK("running control", 32'h03, rd)
            irq_gap(gap);
            `CHK("timer period", 6 * mult[s], gap)
            wr(`OFS_CONTROL, 8'h00);
            repeat (4) @(posedge clk_i);
            rdr(`OFS_CONTROL);
            `CHK("stopped control", 32'h00, rd)
        end
        // A stopped timer must stay silent.
        hit = 1'b0;
        repeat (60)
        begin
            @(posedge clk_i);
            if (timer_irq_o === 1'b1)
                hit = 1'b1;
        end
        `CHK("stopped irq", 1'b0, hit)
        // Outside waveform mode the pin follows the port latch.
        wr(`OFS_OUTPUT, 8'h02);
        repeat (2) @(posedge clk_i);
        `CHK("pin latch", 1'b1, pulse_output_pin_o)
        wr(`OFS_OUTPUT, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK("pin latch", 1'b0, pulse_output_pin_o)
        // The one-shot trigger is ignored in timer mode and taken in one-shot mode.
        wr(`OFS_CONTROL, 8'h01);
        wr(`OFS_ONE_SHOT, 8'h01);
        rdr(`OFS_ONE_SHOT);
        `CHK("one-shot in timer", 32'h00, rd)
        wr(`OFS_CONTROL, 8'h04);
        wr(`OFS_MODE, 8'h02);
        wr(`OFS_CONTROL, 8'h01);
        wr(`OFS_ONE_SHOT, 8'h01);
        rdr(`OFS_ONE_SHOT);
        `CHK("one-shot flag", 32'h02, rd)
        // Forced stop clears the flags and reloads prescaler, secondary and primary with all ones.
        wr(`OFS_CONTROL, 8'h04);
        rdr(`OFS_ONE_SHOT);
        `CHK("flag after stop", 32'h00, rd)
        rdr(`OFS_CONTROL);
        `CHK("control after stop", 32'h00, rd)
        for (int i = 4; i < 7; i++)
        begin
            rdr(rows[i].adr);
            `CHK("value after stop", 32'hFF, rd)
        end
        // The wait one-shot encoding enables the one-shot register as well.
        wr(`OFS_MODE, 8'h03);
        wr(`OFS_CONTROL, 8'h01);
        wr(`OFS_ONE_SHOT, 8'h01);
        rdr(`OFS_ONE_SHOT);
        `CHK("wait one-shot flag", 32'h02, rd)
        wr(`OFS_CONTROL, 8'h04);
        // Waveform: primary 1+1 clocks, secondary 3+1 clocks, prescaler 0.
        wr(`OFS_MODE, 8'h01);
        wr(`OFS_PRESCALER, 8'h00);
        wr(`OFS_SECONDARY, 8'h03);
        wr(`OFS_PRIMARY, 8'h01);
        wr(`OFS_CONTROL, 8'h01);
        pin_gap(gap, hit);
        `CHK("irq after primary", 1'b0, hit)
        pin_gap(gap, hit);
        `CHK("secondary width", 4, gap)
        `CHK("irq after secondary", 1'b1, hit)
        pin_gap(gap, hit);
        `CHK("primary width", 2, gap)
        `CHK("irq after primary", 1'b0, hit)
        // Spaced reads hit every phase; only the secondary count can exceed 1.
        hit = 1'b0;
        repeat (6)
        begin
            rdr(`OFS_PRIMARY);
            @(posedge clk_i);
            if (rd[7:0] > 8'h01)
                hit = 1'b1;
        end
        `CHK("count readback", 1'b1, hit)
        // Running writes with the prescaler at FFh: the timer steps every 256 clocks.
        wr(`OFS_CONTROL, 8'h04);
        wr(`OFS_MODE, 8'h08);
        wr(`OFS_PRIMARY, 8'h02);
        wr(`OFS_CONTROL, 8'h01);
        wr(`OFS_PRIMARY, 8'h05);
        repeat (300) @(posedge clk_i);
        rdr(`OFS_PRIMARY);
        `CHK("reload-only write", 1'b1, rd[7:0] <= 8'h02)
        wr(`OFS_CONTROL, 8'h04);
        wr(`OFS_MODE, 8'h00);
        wr(`OFS_PRIMARY, 8'h02);
        wr(`OFS_CONTROL, 8'h01);
        wr(`OFS_PRIMARY, 8'h05);
        rdr(`OFS_PRIMARY);
        `CHK("write not immediate", 1'b1, rd[7:0] <= 8'h02)
        repeat (300) @(posedge clk_i);
        rdr(`OFS_PRIMARY);
        `CHK("write to both", 32'h05, rd)
        wr(`OFS_CONTROL, 8'h04);
        wrap_up();
    end
endmodule // reload_timer_tb
